// >>> hw/remote_ctl_if.sv
// Remote controller interface: channel/mode decode, FSK bits, audio link, power D/A steering
`timescale 1ns/10ps
module remote_ctl_if #(
  parameter int SAMPLE_W = 16,
  parameter int SAMPLE_DIV = remote_ctl_pkg::SAMPLE_DIV
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [3:0] channel_pick_lines_n,
  input wire logic [1:0] mode_pick_n,
  input wire logic fsk_symbol_bit_a,
  input wire logic fsk_symbol_bit_b,
  input wire logic ref_10mhz,
  input wire logic [SAMPLE_W-1:0] audio_sample,
  input wire remote_ctl_pkg::power_write_t power_write,
  input wire logic [remote_ctl_pkg::STATUS_W-1:0] unit_status,
  output remote_ctl_pkg::remote_cmd_t remote_cmd,
  output logic cmd_update,
  output logic [3:0] fsk_word,
  output logic adc_sample_clk,
  output logic link_clk,
  output logic link_frame,
  output logic link_data,
  output logic [remote_ctl_pkg::DAC_W-1:0] dac_fwd_code,
  output logic [remote_ctl_pkg::DAC_W-1:0] dac_ref_code,
  output logic dac_fwd_load,
  output logic dac_ref_load,
  output logic [remote_ctl_pkg::MV_W-1:0] forward_power_level_out,
  output logic [remote_ctl_pkg::MV_W-1:0] reflected_power_level_out,
  output logic [remote_ctl_pkg::STATUS_W-1:0] remote_status,
  output logic [remote_ctl_pkg::STATUS_W-1:0] terminal_status
);
  import remote_ctl_pkg::*;

  // Level in millivolts; full code maps to exactly full scale
  function automatic logic [MV_W-1:0] scale_mv(input logic [DAC_W-1:0] code);
    logic [31:0] wide;
    wide = (32'(code) * 32'(FULL_SCALE_MV)) / ((32'h1 << DAC_W) - 32'h1);
    return wide[MV_W-1:0];
  endfunction : scale_mv

  logic [3:0] chan_s;
  logic [1:0] mode_s;
  logic [1:0] fsk_s;
  logic ref_s;
  logic ref_prev;

  level_sync #(.W(4), .IDLE(CHAN_LINES_IDLE)) u_chan_sync (
    .ref_clk(ref_clk), .rst_b(rst_b), .async_in(channel_pick_lines_n), .sync_out(chan_s));
  level_sync #(.W(2), .IDLE(MODE_LINES_IDLE)) u_mode_sync (
    .ref_clk(ref_clk), .rst_b(rst_b), .async_in(mode_pick_n), .sync_out(mode_s));
  level_sync #(.W(2), .IDLE(FSK_LINES_IDLE)) u_fsk_sync (
    .ref_clk(ref_clk), .rst_b(rst_b), .async_in({fsk_symbol_bit_b, fsk_symbol_bit_a}),
    .sync_out(fsk_s));
  // Reference sampled at 125 MHz; 10 MHz leaves at least 6 samples per level
  level_sync #(.W(1), .IDLE(1'b0)) u_ref_sync (
    .ref_clk(ref_clk), .rst_b(rst_b), .async_in(ref_10mhz), .sync_out(ref_s));

  // Command decode
  wire [CHAN_W-1:0] next_channel = CHAN_W'({1'b0, ~chan_s}) + 5'h01;
  // Line 1 grounded forces analog; line 2 only picks the FSK order
  wire mode_t next_mode = !mode_s[0] ? MODE_ANALOG :
                          (mode_s[1] ? MODE_FSK4 : MODE_FSK2);
  wire remote_cmd_t next_cmd = '{channel: next_channel, mode: next_mode};
  wire cmd_changed = next_cmd != remote_cmd;
  wire analog = remote_cmd.mode == MODE_ANALOG;
  wire [3:0] next_fsk = analog ? 4'h0 :
                        {2'b00, remote_cmd.mode == MODE_FSK4 ? fsk_s[1] : 1'b0, fsk_s[0]};
  wire ref_rise = ref_s && !ref_prev;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      remote_cmd <= '{channel: RESET_CHANNEL, mode: MODE_FSK4};
      cmd_update <= 1'b0;
      fsk_word <= 4'h0;
      ref_prev <= 1'b0;
    end else begin
      remote_cmd <= next_cmd;
      cmd_update <= cmd_changed;
      fsk_word <= next_fsk;
      ref_prev <= ref_s;
    end
  end

  // Sample pacing and serial link, advanced on reference edges only
  logic [15:0] ref_count;
  logic [SAMPLE_W-1:0] shift;
  logic [$clog2(SAMPLE_W+1)-1:0] bit_count;
  logic busy;
  wire sample_tick = ref_rise && (ref_count == 16'(SAMPLE_DIV - 1));
  wire start_frame = sample_tick && analog;
  wire last_bit = bit_count == ($bits(bit_count))'(SAMPLE_W - 1);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_count <= 16'h0000;
    end else if (ref_rise) begin
      ref_count <= sample_tick ? 16'h0000 : ref_count + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      adc_sample_clk <= 1'b0;
      busy <= 1'b0;
      shift <= '0;
      bit_count <= '0;
      link_clk <= 1'b0;
      link_frame <= 1'b0;
      link_data <= 1'b0;
    end else begin
      adc_sample_clk <= sample_tick;
      if (start_frame) begin
        busy <= 1'b1;
        shift <= audio_sample;
        bit_count <= '0;
        link_clk <= 1'b0;
        link_frame <= 1'b1;
        link_data <= audio_sample[SAMPLE_W-1];
      end else if (busy && ref_rise) begin
        // Data changes on falling link clock; receiver samples on rising
        link_clk <= !link_clk;
        if (link_clk) begin
          link_frame <= 1'b0;
          shift <= shift << 1;
          link_data <= shift[SAMPLE_W-2];
          bit_count <= bit_count + 1'b1;
          if (last_bit) begin
            busy <= 1'b0;
            link_data <= 1'b0;
          end
        end
      end
    end
  end

  // Power write steering into the dual D/A
  wire fwd_hit = power_write.valid && !power_write.to_reflected;
  wire ref_hit = power_write.valid && power_write.to_reflected;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dac_fwd_code <= '0;
      dac_ref_code <= '0;
      dac_fwd_load <= 1'b0;
      dac_ref_load <= 1'b0;
      forward_power_level_out <= '0;
      reflected_power_level_out <= '0;
      remote_status <= '0;
      terminal_status <= '0;
    end else begin
      dac_fwd_load <= fwd_hit;
      dac_ref_load <= ref_hit;
      if (fwd_hit) dac_fwd_code <= power_write.code;
      if (ref_hit) dac_ref_code <= power_write.code;
      forward_power_level_out <= scale_mv(dac_fwd_code);
      reflected_power_level_out <= scale_mv(dac_ref_code);
      remote_status <= unit_status;
      terminal_status <= unit_status;
    end
  end

  // Checks
  property p_channel_decode;
    @(posedge ref_clk) disable iff (!rst_b)
      remote_cmd.channel == $past(next_channel) && remote_cmd.channel != 5'h00;
  endproperty
  a_channel_decode: assert property (p_channel_decode) else $error("channel decode wrong");

  property p_mode_analog;
    @(posedge ref_clk) disable iff (!rst_b)
      $past(!mode_s[0]) |-> remote_cmd.mode == MODE_ANALOG ##1 fsk_word == 4'h0;
  endproperty
  a_mode_analog: assert property (p_mode_analog) else $error("grounded mode line not analog");

  property p_three_modes;
    @(posedge ref_clk) disable iff (!rst_b)
      remote_cmd.mode != 2'b10 and ($past(mode_s == 2'b11) |-> remote_cmd.mode == MODE_FSK4);
  endproperty
  a_three_modes: assert property (p_three_modes) else $error("mode outside reachable set");

  property p_fsk_bits;
    @(posedge ref_clk) disable iff (!rst_b)
      fsk_word[3:2] == 2'b00 and (remote_cmd.mode == MODE_FSK2 |=> fsk_word[1] == 1'b0);
  endproperty
  a_fsk_bits: assert property (p_fsk_bits) else $error("inactive FSK bit driven");

  property p_frame_analog;
    @(posedge ref_clk) disable iff (!rst_b)
      $rose(link_frame) |-> $past(analog) && adc_sample_clk;
  endproperty
  a_frame_analog: assert property (p_frame_analog) else $error("frame outside analog mode");

  property p_sample_on_ref;
    @(posedge ref_clk) disable iff (!rst_b)
      adc_sample_clk |-> $past(ref_rise) ##1 !adc_sample_clk;
  endproperty
  a_sample_on_ref: assert property (p_sample_on_ref) else $error("sample pulse off reference");

  property p_dac_steer;
    @(posedge ref_clk) disable iff (!rst_b)
      fwd_hit |=> dac_fwd_code == $past(power_write.code) && $stable(dac_ref_code) && dac_fwd_load;
  endproperty
  a_dac_steer: assert property (p_dac_steer) else $error("forward write misdirected");

  property p_level_scale;
    @(posedge ref_clk) disable iff (!rst_b)
      forward_power_level_out <= MV_W'(FULL_SCALE_MV) and
      ($past(dac_ref_code) == {DAC_W{1'b1}} |-> reflected_power_level_out == MV_W'(FULL_SCALE_MV));
  endproperty
  a_level_scale: assert property (p_level_scale) else $error("level scale wrong");

  property p_status;
    @(posedge ref_clk) disable iff (!rst_b)
      remote_status == $past(unit_status) && terminal_status == remote_status;
  endproperty
  a_status: assert property (p_status) else $error("status not forwarded");

  property p_cmd_update;
    @(posedge ref_clk) disable iff (!rst_b)
      cmd_update |-> remote_cmd != $past(remote_cmd);
  endproperty
  a_cmd_update: assert property (p_cmd_update) else $error("update without change");

  c_frame: cover property (@(posedge ref_clk) disable iff (!rst_b) link_frame ##1 !link_frame);
  c_channel_16: cover property (@(posedge ref_clk) disable iff (!rst_b) remote_cmd.channel == 5'h10);
  c_fsk4: cover property (@(posedge ref_clk) disable iff (!rst_b) remote_cmd.mode == MODE_FSK4
                          && fsk_word == 4'h3);
  c_ref_write: cover property (@(posedge ref_clk) disable iff (!rst_b) dac_ref_load);
endmodule : remote_ctl_if

// >>> hw/remote_ctl_pkg.sv
// Shared constants and types for the remote control interface
// How it works
// - Four active-low channel lines, weights 1/2/4/8, select channel one plus their value (1-16).
// - Mode line low selects analog operation, open (high) selects digital operation.
// - Two mode bits are read; only analog, two-level and four-level are reachable remotely.
// - Four FSK bits go to the modulator, only the first two are active from the controller.
// - In analog mode audio samples are shifted to the modulator with clock and frame pulses.
// - Audio sampling pulses come from a divider running on the ten-MHz reference.
// - Forward and reflected power codes are steered into the proper half of a dual D/A.
// - Each D/A half gives a level proportional to its code, full scale 0 to 2.5 volts.
// - Unit status is reported both to the local terminal and to the remote controller.
// - Remote commands reach the control unit; local control arrives on its own path.
package remote_ctl_pkg;
  localparam int REF_HZ = 10_000_000;
  localparam int SAMPLE_HZ = 8_000;
  localparam int SAMPLE_DIV = REF_HZ / SAMPLE_HZ;
  localparam int DAC_W = 8;
  localparam int FULL_SCALE_MV = 2500;
  localparam int MV_W = 12;
  localparam int STATUS_W = 8;
  localparam int CHAN_W = 5;
  localparam logic [3:0] CHAN_LINES_IDLE = 4'hf;
  localparam logic [1:0] MODE_LINES_IDLE = 2'h3;
  localparam logic [1:0] FSK_LINES_IDLE = 2'h0;
  localparam logic [CHAN_W-1:0] RESET_CHANNEL = 5'h01;

  typedef enum logic [1:0] {
    MODE_ANALOG = 2'b00,
    MODE_FSK2 = 2'b01,
    MODE_FSK4 = 2'b11
  } mode_t;

  typedef struct packed {
    logic [CHAN_W-1:0] channel;
    mode_t mode;
  } remote_cmd_t;

  typedef struct packed {
    logic valid;
    logic to_reflected;
    logic [DAC_W-1:0] code;
  } power_write_t;
endpackage : remote_ctl_pkg

// >>> hw/level_sync.sv
// Two-stage synchroniser for a group of slow asynchronous levels
`timescale 1ns/10ps
module level_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE = '0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= IDLE;
      sync_out <= IDLE;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : level_sync

// >>> tb/remote_ctl_partner.sv
// Behavioural remote controller: reference clock, select lines and data bits
`timescale 1ns/10ps
module remote_ctl_partner (
  input wire logic [4:0] channel_want,
  input wire remote_ctl_pkg::mode_t mode_want,
  input wire logic [1:0] data_want,
  output logic ref_10mhz,
  output logic [3:0] channel_pick_lines_n,
  output logic [1:0] mode_pick_n,
  output logic fsk_symbol_bit_a,
  output logic fsk_symbol_bit_b
);
  import remote_ctl_pkg::*;
  logic [4:0] chan_less_one;
  logic [1:0] digital_lines;
  initial begin
    ref_10mhz = 1'b0;
    // Offset keeps every reference edge clear of a system clock edge
    #1;
    forever #50 ref_10mhz = ~ref_10mhz;
  end
  assign chan_less_one = channel_want - 5'h01;
  assign channel_pick_lines_n = ~chan_less_one[3:0];
  // Line 1 low means analog, line 2 then picks two or four levels
  assign digital_lines = (mode_want == MODE_FSK2) ? 2'h1 : 2'h3;
  assign mode_pick_n = (mode_want == MODE_ANALOG) ? 2'h0 : digital_lines;
  // Only the first two data bits are ever driven
  assign fsk_symbol_bit_a = data_want[0];
  assign fsk_symbol_bit_b = data_want[1];
endmodule : remote_ctl_partner

// >>> tb/test_remote_ctl_if.sv
// Self-checking testbench for the remote control interface
`timescale 1ns/10ps
module test_remote_ctl_if;
  import remote_ctl_pkg::*;
  logic ref_clk, rst_b, ref_10mhz, fsk_symbol_bit_a, fsk_symbol_bit_b;
  logic cmd_update, adc_sample_clk, link_clk, link_frame, link_data;
  logic dac_fwd_load, dac_ref_load;
  logic [3:0] channel_pick_lines_n;
  logic [3:0] fsk_word;
  logic [1:0] mode_pick_n, data_want;
  logic [4:0] channel_want;
  mode_t mode_want;
  logic [15:0] audio_sample;
  power_write_t power_write;
  logic [7:0] unit_status, remote_status, terminal_status, dac_fwd_code, dac_ref_code;
  logic [11:0] forward_power_level_out, reflected_power_level_out;
  remote_cmd_t remote_cmd;
  int num_errors, num_checks;

  remote_ctl_partner partner_u (.channel_want, .mode_want, .data_want, .ref_10mhz,
    .channel_pick_lines_n, .mode_pick_n, .fsk_symbol_bit_a, .fsk_symbol_bit_b);

  // Short sample period keeps the run brief
  remote_ctl_if #(.SAMPLE_W(16), .SAMPLE_DIV(40)) dut_u (.ref_clk, .rst_b,
    .channel_pick_lines_n, .mode_pick_n, .fsk_symbol_bit_a, .fsk_symbol_bit_b, .ref_10mhz,
    .audio_sample, .power_write, .unit_status, .remote_cmd, .cmd_update, .fsk_word,
    .adc_sample_clk, .link_clk, .link_frame, .link_data, .dac_fwd_code, .dac_ref_code,
    .dac_fwd_load, .dac_ref_load, .forward_power_level_out, .reflected_power_level_out,
    .remote_status, .terminal_status);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic give_verdict;
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Waits on link clock, frame, sample pulse or update pulse, never forever
  task automatic await(input int sel, input logic lvl, output int n);
    logic [3:0] s;
    for (n = 0; n < 700; n++) begin
      tick(1);
      s = {cmd_update, adc_sample_clk, link_frame, link_clk};
      if (s[sel] === lvl) return;
    end
    num_errors++;
    give_verdict;
  endtask : await

  task automatic check_channels;
    int n;
    // Channel 1 is the reset value, so it comes last to force a change
    for (int k = 0; k < 16; k++) begin
      channel_want = 5'((k + 1) % 16 + 1);
      await(3, 1'b1, n);
      check(remote_cmd.channel, channel_want);
    end
  endtask : check_channels

  task automatic check_modes;
    mode_t mlist[3] = '{MODE_ANALOG, MODE_FSK2, MODE_FSK4};
    logic [3:0] flist[3] = '{4'h0, 4'h1, 4'h3};
    int n;
    data_want = 2'h3;
    for (int i = 0; i < 3; i++) begin
      mode_want = mlist[i];
      await(3, 1'b1, n);
      tick(2);
      check(remote_cmd.mode, mlist[i]);
      check(fsk_word, flist[i]);
    end
  endtask : check_modes

  task automatic check_power;
    power_write = {1'b1, 1'b0, 8'hff};
    tick(1);
    check({dac_fwd_load, dac_ref_load, dac_fwd_code}, {2'b10, 8'hff});
    power_write = {1'b1, 1'b1, 8'h33};
    tick(1);
    check({dac_fwd_load, dac_ref_load, dac_ref_code, dac_fwd_code}, {2'b01, 16'h33ff});
    check(forward_power_level_out, 12'h9c4);
    power_write = '0;
    tick(1);
    check({dac_fwd_load, dac_ref_load, reflected_power_level_out}, {2'b00, 12'h1f4});
  endtask : check_power

  task automatic check_link;
    int n;
    logic seen_frame;
    logic [15:0] cap;
    // Previous scenario ends in four-level, so pick two-level to see an update
    mode_want = MODE_FSK2;
    await(3, 1'b1, n);
    await(2, 1'b1, n);
    await(2, 1'b1, n);
    check(n >= 498 && n <= 500, 1'b1);
    // No frame may appear while digital
    seen_frame = 1'b0;
    repeat (600) begin
      tick(1);
      seen_frame = seen_frame | link_frame;
    end
    check(seen_frame, 1'b0);
    mode_want = MODE_ANALOG;
    await(1, 1'b1, n);
    for (int i = 15; i >= 0; i--) begin
      await(0, 1'b1, n);
      cap[i] = link_data;
      await(0, 1'b0, n);
    end
    check(cap, audio_sample);
  endtask : check_link

  initial begin
    rst_b = 1'b0;
    channel_want = 5'h01;
    mode_want = MODE_FSK4;
    data_want = 2'h0;
    audio_sample = 16'ha5c3;
    power_write = '0;
    unit_status = 8'h00;
    num_errors = 0;
    num_checks = 0;
    tick(3);
    rst_b = 1'b1;
    tick(3);
    check(remote_cmd, {RESET_CHANNEL, MODE_FSK4});
    check({fsk_word, dac_fwd_code, dac_ref_code}, 20'h00000);
    check_channels;
    check_modes;
    check_power;
    unit_status = 8'h5a;
    tick(2);
    check({remote_status, terminal_status}, 16'h5a5a);
    check_link;
    give_verdict;
  end
endmodule : test_remote_ctl_if
